// ### inc/event_count_params.svh
/*
 Offsets, field positions, reset values and timing counts of the event counter.
 Assumes the including file uses the offsets with the 6-bit address width noted beside them.
*/
`ifndef EVENT_COUNT_PARAMS_SVH
`define EVENT_COUNT_PARAMS_SVH

// Byte offsets on the register bus (6-bit address)
`define OFS_CONTROL 6'h00
`define OFS_PRESCALE 6'h04
`define OFS_COUNT 6'h08
`define OFS_MATCH0 6'h0c
`define OFS_MATCH1 6'h10
`define OFS_LATCH 6'h14
`define OFS_STATUS 6'h18
`define OFS_EDGE 6'h1c
`define OFS_SAMPLE 6'h20

// Control register bit positions
`define BIT_WIDTH 0
`define BIT_CLR0 1
`define BIT_CLR1 2
`define BIT_RUN 3
`define BIT_CAPSEL 4

// Status register bit positions, write one to clear
`define BIT_OVF 0
`define BIT_EDGE_FLAG 1
`define BIT_MATCH0_FLAG 2
`define BIT_MATCH1_FLAG 3

// Reset values
`define RST_PRESCALE 4'h1
`define RST_EDGE 2'h0
`define RST_SAMPLE 2'h0

// Prescale code that selects the external event as count clock
`define PRESCALE_EXT 4'hf
// Shortest internal count divider, in system clocks
`define PRESCALE_BASE 12'h008
// Consecutive equal samples before a pin level is accepted
`define FILTER_LEN 3

`endif

// ### inc/event_count_pkg.sv
/*
 Types shared by the event counter: control fields and edge selection.
 Assumes event_count_params.svh for the bit positions behind these fields.
*/
package event_count_pkg;

    // Software control bits as one carrier
    typedef struct packed {
        logic capture_or_match_select;
        logic count_run;
        logic clear_on_match_one;
        logic clear_on_match_zero;
        logic width_select;
    } timer_control_t;

    // Edge polarity choice for the event pin
    typedef enum logic [1:0] {
        edge_fall = 2'h0,
        edge_rise = 2'h1,
        edge_both = 2'h2,
        edge_both_alt = 2'h3
    } edge_polarity_t;

endpackage

// ### hdl/event_count_capture_compare.sv
/*
 Event counter with two compare channels and two capture paths, reached over Avalon-MM.
 Assumes one 100 MHz clock mclk, asynchronous active-high reset, and an asynchronous event pin.
*/
// Implementation choices: the placing of the registers and register access over Avalon-MM.
// Overview of operation
// - External count clock needs only prescale selection
// - Event rate and width follow sampling clock
// - Same maximum rate for one or both edges
// - Starting run zeroes count, counts from the second tick
// - Stopping run zeroes count at once
// - Rewriting run while running changes nothing
// - Increment equal to match raises match interrupt
// - Clear-on-match makes repeating interval timer
// - Valid pin edge latches count into captures
// - Edge register picks capture trigger polarity
// - Capture mode with clear clears after latch
// - Capture clear passes N+1 through compare
// - Width bit selects 8 or 16 bit counting
// - All-ones wraps, sets overflow until software clears
// - Clearance takes effect on next count tick
// - Compare checked only on counter increment or capture-clear tick
`timescale 1ns/100ps
`include "event_count_params.svh"

module event_count_capture_compare #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Event pin
    input wire logic event_input_pin,
    // Event pulses
    output logic match_irq_zero,
    output logic match_irq_one,
    output logic edge_irq
);

    // Mask a value to the selected counter width
    function automatic logic [CNT_W-1:0] wmask(input logic [CNT_W-1:0] v, input logic wide);
        wmask = wide ? v : {{(CNT_W-8){1'b0}}, v[7:0]};
    endfunction

    event_count_pkg::timer_control_t timer_control;
    logic [3:0] clock_prescale_select;
    logic [1:0] edge_polarity_select;
    logic [1:0] sample_clock_select;
    logic [CNT_W-1:0] timer_count, match_value_zero, match_or_latch_one, latch_value;
    logic overflow_flag, edge_flag, match0_flag, match1_flag;
    logic start_pend, clr_pend, cap_clr;
    logic [11:0] div_cnt;
    logic [7:0] samp_cnt;
    logic pin_s1, pin_s2;
    logic [`FILTER_LEN-1:0] hist;
    logic filt_lvl, filt_prev, detected_edge_signal;

    // Bus decode
    wire req = read | write;
    wire wr_ok = write & ~waitrequest;
    wire wr_ctrl = wr_ok & (address == `OFS_CONTROL);
    wire wr_stat = wr_ok & (address == `OFS_STATUS);
    wire [3:0] stat_clr = wr_stat ? writedata[3:0] : 4'h0;
    wire run = timer_control.count_run;
    wire wide = timer_control.width_select;
    wire cap_mode = timer_control.capture_or_match_select;
    wire next_wait = ~(req & waitrequest);
    // A stop write zeroes the count on its own edge, not one later
    wire stop_wr = wr_ctrl & ~writedata[`BIT_RUN];

    // Count clock: internal divider or detected edge
    wire [11:0] div_mask = (`PRESCALE_BASE << clock_prescale_select[3:0]) - 12'h001;
    wire ext_sel = (clock_prescale_select == `PRESCALE_EXT);
    wire int_tick = ((div_cnt & div_mask) == div_mask);
    wire count_tick = ext_sel ? detected_edge_signal : int_tick;

    // Sampling clock enable; mclk setting samples every cycle
    wire [7:0] samp_mask = (sample_clock_select == 2'h0) ? 8'h00 :
                           (sample_clock_select == 2'h1) ? 8'h3f :
                           (sample_clock_select == 2'h2) ? 8'h7f : 8'hff;
    wire samp_en = ((samp_cnt & samp_mask) == samp_mask);
    wire [`FILTER_LEN-1:0] next_hist = {hist[`FILTER_LEN-2:0], pin_s2};
    wire all_hi = &next_hist;
    wire all_lo = ~|next_hist;

    // Edge qualification by polarity
    wire rise = filt_lvl & ~filt_prev;
    wire fall = ~filt_lvl & filt_prev;
    wire next_edge = edge_polarity_select[1] ? (rise | fall) :
                     edge_polarity_select[0] ? rise : fall;

    // Compare on the incremented value only
    wire [CNT_W-1:0] top = wmask({CNT_W{1'b1}}, wide);
    wire [CNT_W-1:0] inc = wmask(timer_count + {{(CNT_W-1){1'b0}}, 1'b1}, wide);
    wire cmp_ok = run & count_tick & ~start_pend & (~clr_pend | cap_clr);
    wire hit0 = cmp_ok & (inc == match_value_zero);
    wire hit1 = cmp_ok & ~cap_mode & (inc == match_or_latch_one);
    wire capture = run & detected_edge_signal;
    wire cap_clear_set = capture & cap_mode & timer_control.clear_on_match_one;
    wire clr_set = (hit0 & timer_control.clear_on_match_zero)
                 | (hit1 & timer_control.clear_on_match_one) | cap_clear_set;
    wire next_clr_pend = run & (clr_set | (clr_pend & ~count_tick));
    wire next_cap_clr = run & (cap_clear_set | (cap_clr & ~count_tick));
    wire ovf_set = run & count_tick & ~start_pend & ~clr_pend & (timer_count == top);

    // Read mux; unmapped offsets read zero
    wire [31:0] rd_mux =
        (address == `OFS_CONTROL) ? {27'h0, timer_control.capture_or_match_select, run,
                                     timer_control.clear_on_match_one, timer_control.clear_on_match_zero, wide} :
        (address == `OFS_PRESCALE) ? {28'h0, clock_prescale_select} :
        (address == `OFS_COUNT) ? {{(32-CNT_W){1'b0}}, timer_count} :
        (address == `OFS_MATCH0) ? {{(32-CNT_W){1'b0}}, match_value_zero} :
        (address == `OFS_MATCH1) ? {{(32-CNT_W){1'b0}}, match_or_latch_one} :
        (address == `OFS_LATCH) ? {{(32-CNT_W){1'b0}}, latch_value} :
        (address == `OFS_STATUS) ? {28'h0, match1_flag, match0_flag, edge_flag, overflow_flag} :
        (address == `OFS_EDGE) ? {30'h0, edge_polarity_select} :
        (address == `OFS_SAMPLE) ? {30'h0, sample_clock_select} : 32'h0;

    // One wait cycle per access; write lands when waitrequest is seen low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else begin
            waitrequest <= next_wait;
            readdata <= rd_mux;
        end
    end

    // Software-written configuration
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_control <= '0;
            clock_prescale_select <= `RST_PRESCALE;
            edge_polarity_select <= `RST_EDGE;
            sample_clock_select <= `RST_SAMPLE;
            match_value_zero <= '0;
        end else if (wr_ok) begin
            if (wr_ctrl) timer_control <= {writedata[`BIT_CAPSEL], writedata[`BIT_RUN],
                                          writedata[`BIT_CLR1], writedata[`BIT_CLR0], writedata[`BIT_WIDTH]};
            if (address == `OFS_PRESCALE) clock_prescale_select <= writedata[3:0];
            if (address == `OFS_EDGE) edge_polarity_select <= writedata[1:0];
            if (address == `OFS_SAMPLE) sample_clock_select <= writedata[1:0];
            if (address == `OFS_MATCH0) match_value_zero <= writedata[CNT_W-1:0];
        end
    end

    // Dual-purpose register: software value, or capture when in capture mode
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) match_or_latch_one <= '0;
        else if (capture & cap_mode) match_or_latch_one <= timer_count;
        else if (wr_ok & (address == `OFS_MATCH1)) match_or_latch_one <= writedata[CNT_W-1:0];
    end

    // Dedicated capture register holds until the next trigger
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) latch_value <= '0;
        else if (capture) latch_value <= timer_count;
    end

    // Free-running dividers for count and sampling clocks
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_cnt <= 12'h0;
            samp_cnt <= 8'h0;
        end else begin
            div_cnt <= div_cnt + 12'h001;
            samp_cnt <= samp_cnt + 8'h01;
        end
    end

    // Pin synchroniser, then a level filter; short pulses are dropped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            hist <= '0;
            filt_lvl <= 1'b0;
        end else begin
            pin_s1 <= event_input_pin;
            pin_s2 <= pin_s1;
            if (samp_en) begin
                hist <= next_hist;
                if (all_hi | all_lo) filt_lvl <= all_hi;
            end
        end
    end

    // One edge pulse per qualified transition, either polarity alike
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            filt_prev <= 1'b0;
            detected_edge_signal <= 1'b0;
        end else begin
            filt_prev <= filt_lvl;
            detected_edge_signal <= next_edge;
        end
    end

    // Pending clears; set wins over the consuming tick
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            start_pend <= 1'b0;
            clr_pend <= 1'b0;
            cap_clr <= 1'b0;
        end else begin
            if (wr_ctrl & writedata[`BIT_RUN] & ~run) start_pend <= 1'b1;
            else if (count_tick | ~run) start_pend <= 1'b0;
            clr_pend <= next_clr_pend;
            cap_clr <= next_cap_clr;
        end
    end

    // Counter proper
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) timer_count <= '0;
        else if (~run | stop_wr) timer_count <= '0;
        else if (count_tick) begin
            if (start_pend | clr_pend) timer_count <= '0;
            else timer_count <= inc;
        end
    end

    // Sticky flags and event pulses; hardware set beats software clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            overflow_flag <= 1'b0;
            edge_flag <= 1'b0;
            match0_flag <= 1'b0;
            match1_flag <= 1'b0;
            match_irq_zero <= 1'b0;
            match_irq_one <= 1'b0;
            edge_irq <= 1'b0;
        end else begin
            overflow_flag <= ovf_set | (overflow_flag & ~stat_clr[`BIT_OVF]);
            edge_flag <= detected_edge_signal | (edge_flag & ~stat_clr[`BIT_EDGE_FLAG]);
            match0_flag <= hit0 | (match0_flag & ~stat_clr[`BIT_MATCH0_FLAG]);
            match1_flag <= hit1 | (match1_flag & ~stat_clr[`BIT_MATCH1_FLAG]);
            match_irq_zero <= hit0;
            match_irq_one <= hit1;
            edge_irq <= detected_edge_signal;
        end
    end

    // Checks next to the logic
    stop_zero_a: assert property (@(posedge mclk) disable iff (reset)
        $fell(run) |-> timer_count == '0) else $error("count not zero after stop");
    start_zero_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(run) |-> timer_count == '0 ##1 (start_pend | timer_count == '0 | ~run)) else $error("bad start");
    rerun_keep_a: assert property (@(posedge mclk) disable iff (reset)
        (wr_ctrl & run & writedata[`BIT_RUN] & ~count_tick) |=> $stable(timer_count)) else $error("rerun disturbed");
    match_irq_a: assert property (@(posedge mclk) disable iff (reset)
        (cmp_ok & inc == match_value_zero) |=> match_irq_zero & match0_flag) else $error("match0 missed");
    overflow_set_a: assert property (@(posedge mclk) disable iff (reset)
        ovf_set |=> overflow_flag & timer_count == '0) else $error("overflow wrong");
    capture_latch_a: assert property (@(posedge mclk) disable iff (reset)
        capture |=> latch_value == $past(timer_count)) else $error("capture wrong");
    clear_wait_a: assert property (@(posedge mclk) disable iff (reset)
        (clr_pend & run & ~count_tick & ~wr_ctrl) |=> $stable(timer_count)) else $error("early clear");
    clear_tick_a: assert property (@(posedge mclk) disable iff (reset)
        (clr_pend & run & count_tick & ~wr_ctrl) |=> timer_count == '0) else $error("clear missed");
    narrow_width_a: assert property (@(posedge mclk) disable iff (reset)
        ~wide |-> timer_count[CNT_W-1:8] == '0) else $error("8-bit overrun");
    ext_count_a: assert property (@(posedge mclk) disable iff (reset)
        (ext_sel & run & detected_edge_signal & ~start_pend & ~clr_pend & ~wr_ctrl)
        |=> timer_count == $past(inc)) else $error("event not counted");
    // Pulse shape, polarity, compare quietness, capture-clear and overflow hold checks
    edge_one_a: assert property (@(posedge mclk) disable iff (reset)
        detected_edge_signal |=> ~detected_edge_signal) else $error("edge pulse too long");
    edge_fall_a: assert property (@(posedge mclk) disable iff (reset)
        (edge_polarity_select == 2'h0) & rise |=> ~detected_edge_signal) else $error("rise taken as fall");
    match_quiet_a: assert property (@(posedge mclk) disable iff (reset)
        ~count_tick |=> ~match_irq_zero & ~match_irq_one) else $error("match without tick");
    cap_clear_a: assert property (@(posedge mclk) disable iff (reset)
        (cap_clear_set & ~wr_ctrl) |=> clr_pend) else $error("capture clear lost");
    cap_compare_a: assert property (@(posedge mclk) disable iff (reset)
        (cap_clr & run & count_tick & ~start_pend & ~wr_ctrl & (inc == match_value_zero))
        |=> match_irq_zero) else $error("N+1 compare missed");
    ovf_hold_a: assert property (@(posedge mclk) disable iff (reset)
        (overflow_flag & ~stat_clr[`BIT_OVF]) |=> overflow_flag) else $error("overflow flag lost");
    // Reset checked without the disable, so it watches the released state
    reset_state_a: assert property (@(posedge mclk)
        reset |=> (timer_count == '0) & ~run & ~start_pend & ~clr_pend)
        else $error("reset state wrong");

    // Main scenarios
    cover_match_c: cover property (@(posedge mclk) disable iff (reset) hit0 & timer_control.clear_on_match_zero);
    cover_capclr_c: cover property (@(posedge mclk) disable iff (reset) cap_clear_set);
    cover_ovf_c: cover property (@(posedge mclk) disable iff (reset) ovf_set & wide);
    cover_ext_c: cover property (@(posedge mclk) disable iff (reset) ext_sel & count_tick & run);
    cover_slow_c: cover property (@(posedge mclk) disable iff (reset) detected_edge_signal & (sample_clock_select != 2'h0));

endmodule

// ### tb/event_source.sv
/*
 Pulse source standing in for the off-chip event line.
 Assumes the bench calls send_pulses; the line idles low between bursts.
*/
`timescale 1ns/100ps
module event_source (
    // Clock
    input wire logic mclk,
    // Event line
    output logic pin
);
    initial pin = 1'b0;

    // w clocks per level; four clears the three-sample floor at mclk sampling
    task automatic send_pulses(input int n, input int w = 4);
        for (int i = 0; i < n; i++) begin
            repeat (w) @(posedge mclk);
            pin <= 1'b1;
            repeat (w) @(posedge mclk);
            pin <= 1'b0;
        end
        // Let the filter and edge pipeline drain before software looks
        repeat (3 * w) @(posedge mclk);
    endtask
endmodule

// ### tb/tb_top.sv
/*
 Self-checking bench for the event counter: bus tasks, scenarios, verdict.
 Assumes the register map header and the event_source pulse model.
*/
`timescale 1ns/100ps
`include "event_count_params.svh"
module tb_top;
    logic mclk, reset, read, write, waitrequest, pin, irq0, irq1, eirq;
    logic [5:0] address;
    logic [31:0] writedata, readdata, rd;
    int bad_count, checks, n0, n1, ne;

    event_count_capture_compare dut (.mclk(mclk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .event_input_pin(pin), .match_irq_zero(irq0), .match_irq_one(irq1), .edge_irq(eirq));
    event_source src (.mclk(mclk), .pin(pin));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Tally of one-cycle pulses
    always @(posedge mclk) begin
        n0 += (irq0 === 1'b1);
        n1 += (irq1 === 1'b1);
        ne += (eirq === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 50)
            check(32'h0, 32'h1);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic test_reset();
        logic [5:0] ofs [7] = '{`OFS_CONTROL, `OFS_PRESCALE, `OFS_COUNT, `OFS_EDGE, `OFS_SAMPLE, `OFS_STATUS, 6'h3c};
        logic [31:0] val [7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        bus(1'b1, 6'h3c, 32'hff);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, ofs[i], 32'h0);
            check(rd, val[i]);
        end
    endtask

    // External edges, rising only; the first tick after start keeps zero
    task automatic test_ext_count();
        bus(1'b1, `OFS_PRESCALE, 32'hf);
        bus(1'b1, `OFS_EDGE, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h9);
        ne = 0;
        src.send_pulses(1);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rd[1], 32'h1);
        src.send_pulses(4);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h4);
        check(ne, 5);
        bus(1'b0, `OFS_LATCH, 32'h0);
        check(rd, 32'h3);
    endtask

    // Stop, both edges at full rate, rewrite of run, match write without tick
    task automatic test_both_edges();
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, `OFS_EDGE, 32'h2);
        bus(1'b1, `OFS_CONTROL, 32'h9);
        src.send_pulses(3);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h5);
        n0 = 0;
        bus(1'b1, `OFS_CONTROL, 32'h9);
        bus(1'b1, `OFS_MATCH0, 32'h5);
        src.send_pulses(1);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h7);
        check(n0, 0);
    endtask

    // Match 0 with clear, match 1 without: clear lands on the next tick
    task automatic test_match();
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b1, `OFS_EDGE, 32'h1);
        bus(1'b1, `OFS_MATCH0, 32'h3);
        bus(1'b1, `OFS_MATCH1, 32'h2);
        bus(1'b1, `OFS_CONTROL, 32'hb);
        n0 = 0;
        n1 = 0;
        src.send_pulses(4);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h3);
        check(n0, 1);
        src.send_pulses(1);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        src.send_pulses(3);
        check(n0, 2);
        check(n1, 2);
    endtask

    // Dual register as capture: both latches take the same running count
    task automatic test_capture();
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h19);
        src.send_pulses(4);
        bus(1'b0, `OFS_LATCH, 32'h0);
        check(rd, 32'h2);
        bus(1'b0, `OFS_MATCH1, 32'h0);
        check(rd, 32'h2);
    endtask

    // Capture mode with clear: count stays zero, N+1 still matches; then falling edges only
    task automatic test_capture_clear();
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b1, `OFS_MATCH0, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h1d);
        n0 = 0;
        src.send_pulses(3);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        check(n0, 2);
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b1, `OFS_EDGE, 32'h0);
        bus(1'b1, `OFS_CONTROL, 32'h19);
        src.send_pulses(3);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h2);
        bus(1'b0, `OFS_LATCH, 32'h0);
        check(rd, 32'h1);
    endtask

    // Free-running count, software steps the match value after the first hit
    task automatic test_step_match();
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b1, `OFS_EDGE, 32'h1);
        bus(1'b1, `OFS_MATCH0, 32'h2);
        bus(1'b1, `OFS_CONTROL, 32'h9);
        n0 = 0;
        src.send_pulses(3);
        bus(1'b1, `OFS_MATCH0, 32'h4);
        src.send_pulses(2);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h4);
        check(n0, 2);
    endtask

    // Slow sampling: long levels count, levels under three samples are lost
    task automatic test_slow_sample();
        bus(1'b1, `OFS_CONTROL, 32'h1);
        bus(1'b1, `OFS_EDGE, 32'h2);
        bus(1'b1, `OFS_SAMPLE, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h9);
        src.send_pulses(2, 200);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h3);
        src.send_pulses(2);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd, 32'h3);
        bus(1'b1, `OFS_SAMPLE, 32'h0);
    endtask

    // Fastest internal tick in 8-bit mode until wrap
    task automatic test_overflow();
        int n;
        bus(1'b1, `OFS_CONTROL, 32'h0);
        bus(1'b1, `OFS_PRESCALE, 32'h0);
        bus(1'b1, `OFS_CONTROL, 32'h8);
        n = 0;
        do begin
            bus(1'b0, `OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 1500);
        check(rd[0], 32'h1);
        bus(1'b0, `OFS_COUNT, 32'h0);
        check(rd[31:8], 32'h0);
        bus(1'b1, `OFS_STATUS, 32'h1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rd[0], 32'h0);
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        test_reset();
        test_ext_count();
        test_both_edges();
        test_match();
        test_capture();
        test_capture_clear();
        test_step_match();
        test_slow_sample();
        test_overflow();
        end_sim();
    end

    // Watchdog, well beyond the roughly 40 us the scenarios need
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
endmodule
